// [hdl/timer_two_reload_clockout_baud.sv]
// Third 16-bit timer: auto-reload up/down, clock-out and baud generator.
// Assumes an AXI4-Lite master on clk and pins synchronous to clk.
// Contract
// - Down-count enable clears at reset
// - Up/down follows trigger pin level
// - Up overflow at FFFF sets flag, reloads
// - Trigger falling edge reloads, sets external flag
// - Interrupt when enabled and either flag
// - Edge seen over three machine cycles
// - Down underflow at reload, loads FFFF
// - Up/down mode toggles external flag on roll
// - Reload rate is source over 65536-reload
// - Clock-out is oscillator over 2(65536-reload)
// - Clock-out rolls raise no interrupt
// - Serial clock selects pick timer source
// - Baud mode only while select set
// - Baud roll reloads from reload pair
// - Serial rate is overflow rate over 16
// - Baud timer counts every oscillator clock, or pin falls when tcs set
// - Baud rolls set no overflow flag
// - Baud trigger edge flags without reload
// - Serial select forces auto-reload mode
// - Timer counts osc/6, counter pin falls
`timescale 1ns/1ps
module timer_two_reload_clockout_baud (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire timer_two_pkg::axi_req_t axi_req,
  output timer_two_pkg::axi_rsp_t axi_rsp,
  // Timer pin, two-way
  input wire logic tp_i,
  output logic tp_o,
  output logic tp_oe,
  // External trigger pin
  input wire logic trig_pin,
  // Serial port clocking
  input wire logic t1_ovf,
  output logic tx_baud_tick,
  output logic rx_baud_tick,
  // Interrupt request
  output logic irq
);

  timer_two_pkg::timer_state_t st;
  timer_two_pkg::timer_state_t nxt;

  // Mode decode
  logic baud_mode;
  logic clkout_mode;
  logic ar_mode;
  logic cap_mode;
  logic updown;
  logic up_dir;
  // Counting
  logic mc_tick;
  logic tp_fall;
  logic trig_fall;
  logic count_tick;
  logic roll;
  logic trig_evt;
  logic trig_reload;
  logic [15:0] cnt_step;
  // Bus decode
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_cnt;
  logic wr_reload;
  logic tx_src;
  logic rx_src;

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Divide-by-sixteen step: returns next divider and tick
  function automatic logic [4:0] div16(input logic [3:0] div, input logic src);
    logic [4:0] res;
    res = {div, 1'b0};
    if (src) begin
      res = {div + 4'h1, (div == 4'hF)};
    end
    return res;
  endfunction

  // Register read word and response for an address
  function automatic logic [33:0] rd_word(input logic [7:0] addr,
                                          input timer_two_pkg::timer_state_t s);
    logic [33:0] res;
    res = {timer_two_pkg::RESP_OKAY, 32'h0000_0000};
    unique case (addr)
      timer_two_pkg::ADDR_CTRL: begin
        res[7:0] = {s.ovf_flag, s.ext_flag, s.rx_sel, s.tx_sel,
                    s.exen, s.run, s.tcs, s.crs};
      end
      timer_two_pkg::ADDR_MODE: begin
        res[2:0] = {s.irq_en, s.clock_out_enable, s.down_count_enable};
      end
      timer_two_pkg::ADDR_COUNT: begin
        res[15:0] = s.cnt;
      end
      timer_two_pkg::ADDR_RELOAD: begin
        res[15:0] = s.reload;
      end
      default: begin
        // Unmapped reads as zero with an error
        res[33:32] = timer_two_pkg::RESP_SLVERR;
      end
    endcase
    return res;
  endfunction

  // Edge finders for counter input and trigger pin
  fall_edge_sampler u_tp_edge (
    .clk(clk),
    .rstn(rstn),
    .tick(mc_tick),
    .pin(tp_i),
    .fall(tp_fall)
  );

  fall_edge_sampler u_trig_edge (
    .clk(clk),
    .rstn(rstn),
    .tick(mc_tick),
    .pin(trig_pin),
    .fall(trig_fall)
  );

  // Mode and count decode
  always_comb begin
    baud_mode = st.tx_sel | st.rx_sel;
    clkout_mode = st.clock_out_enable & ~st.tcs;
    cap_mode = st.crs & ~baud_mode & ~clkout_mode;
    ar_mode = ~baud_mode & ~clkout_mode & ~st.crs;
    updown = st.down_count_enable & ar_mode;
    up_dir = ~updown | trig_pin;
    mc_tick = (st.mc_cnt == timer_two_pkg::MC_LAST);
    // clock-out counts every clock; baud counts every clock unless tcs selects pin falls
    count_tick = st.run & (st.tcs ? tp_fall : ((baud_mode | clkout_mode) ? 1'b1 : mc_tick));
    // roll at FFFF upward, at reload downward
    roll = count_tick & (up_dir ? (st.cnt == timer_two_pkg::CNT_MAX) : (st.cnt == st.reload));
    // reload period is 65536 minus reload
    if (up_dir) begin
      cnt_step = roll ? (cap_mode ? 16'h0000 : st.reload) : st.cnt + 16'h0001;
    end else begin
      cnt_step = roll ? timer_two_pkg::CNT_MAX : st.cnt - 16'h0001;
    end
    trig_evt = trig_fall & st.exen & ~updown;
    trig_reload = trig_evt & ar_mode;
  end

  // Bus handshake decode
  always_comb begin
    aw_fire = axi_req.awvalid & st.rsp.awready;
    w_fire = axi_req.wvalid & st.rsp.wready;
    ar_fire = axi_req.arvalid & st.rsp.arready;
    do_write = (st.aw_got | aw_fire) & (st.w_got | w_fire);
    wa = st.aw_got ? st.aw_addr : axi_req.awaddr;
    wd = st.w_got ? st.w_data : axi_req.wdata;
    ws = st.w_got ? st.w_strb : axi_req.wstrb;
    wr_ctrl = do_write & (wa == timer_two_pkg::ADDR_CTRL) & ws[0];
    wr_mode = do_write & (wa == timer_two_pkg::ADDR_MODE) & ws[0];
    wr_cnt = do_write & (wa == timer_two_pkg::ADDR_COUNT) & (|ws[1:0]);
    wr_reload = do_write & (wa == timer_two_pkg::ADDR_RELOAD) & (|ws[1:0]);
    tx_src = st.tx_sel ? st.baud_ovf : t1_ovf;
    rx_src = st.rx_sel ? st.baud_ovf : t1_ovf;
  end

  // Next state of the whole block
  always_comb begin
    nxt = st;
    nxt.baud_ovf = 1'b0;
    // Machine cycle prescaler
    nxt.mc_cnt = mc_tick ? 3'h0 : st.mc_cnt + 3'h1;
    // Software writes to control
    if (wr_ctrl) begin
      nxt.ovf_flag = wd[timer_two_pkg::CTRL_OVF];
      nxt.ext_flag = wd[timer_two_pkg::CTRL_EXT];
      nxt.rx_sel = wd[timer_two_pkg::CTRL_RXSEL];
      nxt.tx_sel = wd[timer_two_pkg::CTRL_TXSEL];
      nxt.exen = wd[timer_two_pkg::CTRL_EXEN];
      nxt.run = wd[timer_two_pkg::CTRL_RUN];
      nxt.tcs = wd[timer_two_pkg::CTRL_TCS];
      nxt.crs = wd[timer_two_pkg::CTRL_CRS];
    end
    // Software writes to mode
    if (wr_mode) begin
      nxt.irq_en = wd[timer_two_pkg::MODE_IRQEN];
      nxt.clock_out_enable = wd[timer_two_pkg::MODE_CKOE];
      nxt.down_count_enable = wd[timer_two_pkg::MODE_DOWN];
    end
    // Software writes to reload pair
    if (wr_reload) begin
      nxt.reload = 16'(merge({16'h0000, st.reload}, wd, ws));
    end
    // Count: a software write wins over counting
    if (wr_cnt) begin
      nxt.cnt = 16'(merge({16'h0000, st.cnt}, wd, ws));
    end else if (trig_reload) begin
      nxt.cnt = st.reload;
    end else if (count_tick) begin
      nxt.cnt = cnt_step;
    end
    // Roll-over effects per mode; flag sets win over clears
    if (roll) begin
      if (baud_mode) begin
        // baud roll only pulses the serial side
        nxt.baud_ovf = 1'b1;
      end else if (clkout_mode) begin
        nxt.tp_o = ~st.tp_o;
      end else begin
        nxt.ovf_flag = 1'b1;
        if (updown) begin
          nxt.ext_flag = ~st.ext_flag;
        end
      end
    end
    // trigger edge flags in every mode except up/down counting
    if (trig_evt) begin
      nxt.ext_flag = 1'b1;
    end
    // Pin drive follows clock-out mode
    nxt.tp_oe = clkout_mode;
    {nxt.tx_div, nxt.tx_tick} = div16(st.tx_div, tx_src);
    {nxt.rx_div, nxt.rx_tick} = div16(st.rx_div, rx_src);
    nxt.irq = st.irq_en & (st.ovf_flag | st.ext_flag);
    // Write address and data holding
    if (aw_fire) begin
      nxt.aw_got = 1'b1;
      nxt.aw_addr = axi_req.awaddr;
    end
    if (w_fire) begin
      nxt.w_got = 1'b1;
      nxt.w_data = axi_req.wdata;
      nxt.w_strb = axi_req.wstrb;
    end
    // Write response
    if (do_write) begin
      nxt.aw_got = 1'b0;
      nxt.w_got = 1'b0;
      nxt.rsp.bvalid = 1'b1;
      nxt.rsp.bresp = ((wa == timer_two_pkg::ADDR_CTRL) || (wa == timer_two_pkg::ADDR_MODE) ||
                       (wa == timer_two_pkg::ADDR_COUNT) || (wa == timer_two_pkg::ADDR_RELOAD))
                      ? timer_two_pkg::RESP_OKAY : timer_two_pkg::RESP_SLVERR;
    end else if (st.rsp.bvalid && axi_req.bready) begin
      nxt.rsp.bvalid = 1'b0;
    end
    // Read response
    if (ar_fire) begin
      nxt.rsp.rvalid = 1'b1;
      {nxt.rsp.rresp, nxt.rsp.rdata} = rd_word(axi_req.araddr, st);
    end else if (st.rsp.rvalid && axi_req.rready) begin
      nxt.rsp.rvalid = 1'b0;
    end
    // Ready only while nothing is held or pending
    nxt.rsp.awready = ~nxt.aw_got & ~nxt.rsp.bvalid;
    nxt.rsp.wready = ~nxt.w_got & ~nxt.rsp.bvalid;
    nxt.rsp.arready = ~nxt.rsp.rvalid;
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= timer_two_pkg::TIMER_RST;
    end else begin
      st <= nxt;
    end
  end

  // Outputs straight from the state register
  assign axi_rsp = st.rsp;
  assign tp_o = st.tp_o;
  assign tp_oe = st.tp_oe;
  assign tx_baud_tick = st.tx_tick;
  assign rx_baud_tick = st.rx_tick;
  assign irq = st.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_reset_up;
    @(posedge clk) disable iff (1'b0) !rstn |=> !st.down_count_enable;
  endproperty
  a_reset_up: assert property (p_reset_up) else $error("down count set after reset");

  property p_down_step;
    updown && !trig_pin && count_tick && !roll && !wr_cnt |=> st.cnt == $past(st.cnt) - 16'h0001;
  endproperty
  a_down_step: assert property (p_down_step) else $error("no down count");

  property p_up_roll;
    roll && up_dir && ar_mode && !trig_reload && !wr_cnt
      |=> st.cnt == $past(st.reload) && st.ovf_flag;
  endproperty
  a_up_roll: assert property (p_up_roll) else $error("bad overflow reload");

  property p_edge_reload;
    trig_reload && !wr_cnt |=> st.ext_flag && st.cnt == $past(st.reload);
  endproperty
  a_edge_reload: assert property (p_edge_reload) else $error("bad edge reload");

  property p_irq;
    st.irq_en && (st.ovf_flag || st.ext_flag) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_underflow;
    roll && !up_dir && !wr_cnt |=> st.cnt == 16'hFFFF && st.ovf_flag;
  endproperty
  a_underflow: assert property (p_underflow) else $error("bad underflow");

  property p_toggle17;
    roll && updown && !trig_evt |=> st.ext_flag != $past(st.ext_flag);
  endproperty
  a_toggle17: assert property (p_toggle17) else $error("ext flag no toggle");

  property p_clkout_quiet;
    clkout_mode && !st.ovf_flag && !wr_ctrl |=> !st.ovf_flag;
  endproperty
  a_clkout_quiet: assert property (p_clkout_quiet) else $error("clock-out set flag");

  property p_clkout_toggle;
    roll && clkout_mode |=> tp_o != $past(tp_o) && tp_oe;
  endproperty
  a_clkout_toggle: assert property (p_clkout_toggle) else $error("no pin toggle");

  property p_baud_quiet;
    baud_mode && roll && !st.ovf_flag && !wr_ctrl |=> !st.ovf_flag && st.baud_ovf;
  endproperty
  a_baud_quiet: assert property (p_baud_quiet) else $error("baud roll bad");

  property p_baud_fast;
    baud_mode && !st.tcs && st.run && st.cnt != 16'hFFFF && !wr_cnt
      |=> st.cnt == $past(st.cnt) + 16'h0001;
  endproperty
  a_baud_fast: assert property (p_baud_fast) else $error("baud not every clock");

  property p_baud_edge;
    trig_evt && baud_mode && !wr_cnt
      |=> st.ext_flag && st.cnt == ($past(roll) ? $past(st.reload)
                                    : $past(st.cnt) + 16'($past(count_tick)));
  endproperty
  a_baud_edge: assert property (p_baud_edge) else $error("baud edge reloaded");

  property p_tx_div16;
    st.tx_sel && st.baud_ovf && st.tx_div == 4'hF |=> tx_baud_tick;
  endproperty
  a_tx_div16: assert property (p_tx_div16) else $error("tx tick missing");

endmodule

// [hdl/timer_two_pkg.sv]
// Constants, register map and packed carriers for the third timer/counter.
// Assumes a 20 MHz oscillator clock that also clocks the AXI4-Lite slave.
package timer_two_pkg;

  // Oscillator clock period
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Oscillator clocks per machine cycle
  localparam int unsigned MC_CLKS = 6;
  // Last prescaler value of a machine cycle
  localparam logic [2:0] MC_LAST = 3'(MC_CLKS - 1);

  // Count width and extreme value
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // Bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_RELOAD = 8'h0C;

  // Control register field positions
  localparam int unsigned CTRL_OVF = 7;
  localparam int unsigned CTRL_EXT = 6;
  localparam int unsigned CTRL_RXSEL = 5;
  localparam int unsigned CTRL_TXSEL = 4;
  localparam int unsigned CTRL_EXEN = 3;
  localparam int unsigned CTRL_RUN = 2;
  localparam int unsigned CTRL_TCS = 1;
  localparam int unsigned CTRL_CRS = 0;

  // Mode register field positions
  localparam int unsigned MODE_IRQEN = 2;
  localparam int unsigned MODE_CKOE = 1;
  localparam int unsigned MODE_DOWN = 0;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Master to slave signals
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  // Slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  // Whole state of the timer block
  typedef struct packed {
    logic [2:0] mc_cnt;
    logic ovf_flag;
    logic ext_flag;
    logic rx_sel;
    logic tx_sel;
    logic exen;
    logic run;
    logic tcs;
    logic crs;
    logic clock_out_enable;
    logic down_count_enable;
    logic irq_en;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] reload;
    logic tp_o;
    logic tp_oe;
    logic baud_ovf;
    logic [3:0] tx_div;
    logic [3:0] rx_div;
    logic tx_tick;
    logic rx_tick;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    axi_rsp_t rsp;
  } timer_state_t;

  // State of the falling edge sampler
  typedef struct packed {
    logic samp;
    logic pend;
    logic fall;
  } edge_state_t;

  // Values after reset
  localparam timer_state_t TIMER_RST = '0;
  localparam edge_state_t EDGE_RST = '0;

endpackage

// [hdl/fall_edge_sampler.sv]
// Falling edge finder that samples a pin once per machine cycle.
// Assumes the pin is synchronous to clk and tick marks machine cycles.
`timescale 1ns/1ps
module fall_edge_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Sampling strobe and pin
  input wire logic tick,
  input wire logic pin,
  // One clock pulse, third machine cycle
  output logic fall
);

  timer_two_pkg::edge_state_t st;
  timer_two_pkg::edge_state_t nxt;

  // Sample on the strobe, arm on 1 then 0, fire one cycle on
  always_comb begin
    nxt = st;
    nxt.fall = 1'b0;
    if (tick) begin
      nxt.samp = pin;
      nxt.pend = st.samp & ~pin;
      nxt.fall = st.pend;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= timer_two_pkg::EDGE_RST;
    end else begin
      st <= nxt;
    end
  end

  assign fall = st.fall;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // High sample followed by low sample
  sequence s_hi_then_lo;
    tick && st.samp && !pin;
  endsequence

  property p_edge_arm;
    s_hi_then_lo |=> st.pend;
  endproperty
  a_edge_arm: assert property (p_edge_arm) else $error("edge not armed");

  property p_edge_third;
    s_hi_then_lo ##1 (!tick)[*5] ##1 tick |=> fall;
  endproperty
  a_edge_third: assert property (p_edge_third) else $error("edge late");

endmodule

// [testbench/far_side_model.sv]
// Far side of the timer: pin clock source, trigger pin, timer 1 overflow.
// Assumes the bench changes its commands just after a rising edge.
`timescale 1ns/1ps
module far_side_model #(
  parameter int T1_GAP = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Commands from the bench
  input wire logic pin_clk_en,
  input wire logic t1_en,
  input wire logic trig_lvl,
  // Pins toward the timer
  output logic ext_clk,
  output logic trig_pin,
  output logic t1_ovf
);
  int div_ff; // Clocks since last pin change
  int gap_ff; // Clocks since last pulse
  // Trigger level passes straight to the pin
  assign trig_pin = trig_lvl;
  // Pin clock and overflow pulse makers
  always @(posedge clk) begin
    if (!rstn) begin
      div_ff <= 0;
      gap_ff <= 0;
      ext_clk <= 1'b1;
      t1_ovf <= 1'b0;
    end else begin
      div_ff <= (pin_clk_en && div_ff != 5) ? div_ff + 1 : 0;
      if (pin_clk_en && div_ff == 5) begin
        ext_clk <= ~ext_clk;
      end
      // Pulse every T1_GAP clocks
      gap_ff <= (t1_en && gap_ff != T1_GAP - 1) ? gap_ff + 1 : 0;
      t1_ovf <= t1_en && gap_ff == T1_GAP - 1;
    end
  end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the reload, clock-out and baud timer.
// Assumes the far side model and the design package are compiled first.
`timescale 1ns/1ps
module tb_top;
  localparam int T1_GAP = 5; // Timer 1 pulse spacing
  localparam logic [7:0] A_CT = timer_two_pkg::ADDR_CTRL, A_MD = timer_two_pkg::ADDR_MODE;
  localparam logic [7:0] A_CN = timer_two_pkg::ADDR_COUNT, A_RL = timer_two_pkg::ADDR_RELOAD;
  localparam logic [31:0] C_OVF = 32'h0000_0080, C_EXT = 32'h0000_0040, C_RX = 32'h0000_0020;
  localparam logic [31:0] C_TX = 32'h0000_0010, C_EXEN = 32'h0000_0008, C_RUN = 32'h0000_0004;
  localparam logic [31:0] C_TCS = 32'h0000_0002, M_IRQ = 32'h0000_0004, M_CKO = 32'h0000_0002;
  localparam logic [31:0] M_DC = 32'h0000_0001, FL = 32'h0000_00C0, C_CRS = 32'h0000_0001;
  logic clk = 1'b0; // Oscillator clock
  logic rstn = 1'b0; // Reset, active low
  timer_two_pkg::axi_req_t req = '0; // Bus master side
  timer_two_pkg::axi_rsp_t rsp; // Bus slave side
  logic tp_o, tp_oe, tp_i, ext_clk, trig_pin, t1_ovf, tx_tick, rx_tick, irq;
  logic pin_clk_en = 1'b0, t1_en = 1'b0, trig_lvl = 1'b1; // Far side commands
  int n_mismatch = 0, compares = 0, cyc = 0, ta, tb_;
  logic [15:0] lf = 16'h001A, rl; // Random state, reload value
  logic [31:0] rd, c; // Read data, control value
  logic [1:0] rs; // Response code
  // Clock and cycle count
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // Timer pin level from both drivers
  assign tp_i = tp_oe ? tp_o : ext_clk;
  timer_two_reload_clockout_baud dut_u (.clk(clk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp),
    .tp_i(tp_i), .tp_o(tp_o), .tp_oe(tp_oe), .trig_pin(trig_pin), .t1_ovf(t1_ovf),
    .tx_baud_tick(tx_tick), .rx_baud_tick(rx_tick), .irq(irq));
  far_side_model #(.T1_GAP(T1_GAP)) far_u (.clk(clk), .rstn(rstn), .pin_clk_en(pin_clk_en),
    .t1_en(t1_en), .trig_lvl(trig_lvl), .ext_clk(ext_clk), .trig_pin(trig_pin), .t1_ovf(t1_ovf));
  // Model: clocks between rolls
  function automatic int gap(input logic [15:0] r, input int scale);
    return (65536 - int'(r)) * scale;
  endfunction
  // Random step
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Verdict and end of run
  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Exact compare
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Range compare
  task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                         input logic [31:0] got);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    compares++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error %s expected %h to %h seen %h", nm, lo, hi, got);
    end
  endtask
  // Wait that ran out
  task automatic stuck(input string nm);
    n_mismatch++;
    $display("Error %s expected response seen none", nm);
    summarize();
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic bd;
    bd = 1'b0;
    @(posedge clk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF, bready: 1'b1,
             default: '0};
    for (n = 0; n < 100 && !bd; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (req.bready && rsp.bvalid) begin
        bd = 1'b1;
        r = rsp.bresp;
        req.bready <= 1'b0;
      end
    end
    if (!bd) stuck("write response");
  endtask
  // Bus read
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic got;
    got = 1'b0;
    @(posedge clk);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    for (n = 0; n < 100 && !got; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid) begin
        got = 1'b1;
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
      end
    end
    if (!got) stuck("read data");
  endtask
  // Write expecting an okay response
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk("write response", 32'(timer_two_pkg::RESP_OKAY), 32'(rs));
  endtask
  // Poll control until overflow flag shows
  task automatic poll_ovf();
    int n;
    for (n = 0; n < 60; n++) begin
      rdr(A_CT, rd, rs);
      if ((rd & C_OVF) !== 32'h0000_0000) return;
    end
    stuck("overflow flag");
  endtask
  // Observed signal by number
  function automatic logic ev(input int k);
    case (k)
      0: return irq;
      1: return tp_o;
      2: return tx_tick;
      default: return rx_tick;
    endcase
  endfunction
  // Cycle of next rise, or of any change for the pin
  task automatic wait_ev(input int k, output int t);
    int n;
    logic p, q;
    p = ev(k);
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      q = ev(k);
      if ((k == 1) ? (q !== p) : (q === 1'b1 && p !== 1'b1)) begin
        t = cyc;
        return;
      end
      p = q;
    end
    stuck("event wait");
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdr(8'(4 * i), rd, rs);
      chk("reset value", 32'h0000_0000, rd);
    end
    rdr(8'h10, rd, rs);
    chk("unmapped read resp", 32'(timer_two_pkg::RESP_SLVERR), 32'(rs));
    lf = lfsr_step(lf);
    wr(8'h14, {lf, lf}, rs);
    chk("unmapped write resp", 32'(timer_two_pkg::RESP_SLVERR), 32'(rs));
    $display("Test registers done");
    // Reload period, timer then pin counter
    for (int s = 0; s < 2; s++) begin
      pin_clk_en <= (s == 1);
      rl = (s == 0) ? 16'hFFF0 : 16'hFFF8;
      c = C_RUN | ((s == 1) ? C_TCS : 32'h0000_0000);
      wok(A_CT, 32'h0000_0000);
      wok(A_RL, 32'(rl));
      wok(A_CN, 32'(rl));
      wok(A_MD, M_IRQ);
      wok(A_CT, c);
      wait_ev(0, ta);
      wok(A_CT, c);
      wait_ev(0, tb_);
      chk("reload period", 32'(gap(rl, (s == 0) ? 6 : 12)),
          32'(tb_ - ta));
      rdr(A_CT, rd, rs);
      chk("flags", C_OVF, rd & FL);
    end
    pin_clk_en <= 1'b0;
    $display("Test reload period done");
    // Trigger falling edge reload
    wok(A_CT, 32'h0000_0000);
    wok(A_RL, 32'h0000_1234);
    wok(A_CN, 32'h0000_0000);
    wok(A_CT, C_RUN | C_EXEN);
    repeat (20) @(posedge clk);
    trig_lvl <= 1'b0;
    ta = cyc;
    wait_ev(0, tb_);
    chk_rng("edge to request", 32'h0000_000A, 32'h0000_000F, 32'(tb_ - ta));
    rdr(A_CT, rd, rs);
    chk("flags", C_EXT, rd & FL);
    rdr(A_CN, rd, rs);
    chk_rng("reloaded count", 32'h0000_1234, 32'h0000_123C, rd);
    trig_lvl <= 1'b1;
    $display("Test trigger reload done");
    // Down count, then up again
    wok(A_CT, 32'h0000_0000);
    wok(A_RL, 32'h0000_0100);
    wok(A_CN, 32'h0000_0103);
    wok(A_MD, M_IRQ | M_DC);
    trig_lvl <= 1'b0;
    wok(A_CT, C_RUN);
    wait_ev(0, ta);
    rdr(A_CN, rd, rs);
    chk_rng("underflow count", 32'h0000_FFF0, 32'h0000_FFFF, rd);
    rdr(A_CT, rd, rs);
    chk("flags", FL, rd & FL);
    wok(A_MD, M_DC);
    wok(A_CT, C_RUN | C_EXT);
    trig_lvl <= 1'b1;
    poll_ovf();
    chk("flags", C_OVF, rd & FL);
    rdr(A_CN, rd, rs);
    chk_rng("up roll count", 32'h0000_0100, 32'h0000_0108, rd);
    $display("Test up down done");
    // Clock-out with random reload
    lf = lfsr_step(lf);
    rl = 16'hFFF8 | 16'(lf[1:0]);
    wok(A_CT, 32'h0000_0000);
    wok(A_RL, 32'(rl));
    wok(A_CN, 32'(rl));
    wok(A_MD, M_CKO | M_IRQ);
    wok(A_CT, C_RUN);
    wait_ev(1, ta);
    wait_ev(1, tb_);
    chk("half period", 32'(gap(rl, 1)), 32'(tb_ - ta));
    wait_ev(1, ta);
    chk("other half", 32'(gap(rl, 1)), 32'(ta - tb_));
    chk("pin enable", 32'h0000_0001, 32'(tp_oe));
    chk("request", 32'h0000_0000, 32'(irq));
    rdr(A_CT, rd, rs);
    chk("control", C_RUN, rd);
    $display("Test clock-out done");
    // Baud generation, each select in turn
    wok(A_CT, 32'h0000_0000);
    wok(A_RL, 32'h0000_FFFE);
    wok(A_CN, 32'h0000_FFFE);
    wok(A_MD, M_IRQ);
    t1_en <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      c = C_RUN | ((s == 0) ? C_TX : (C_RX | C_EXEN | C_CRS));
      wok(A_CT, c);
      wait_ev(2, ta);
      wait_ev(2, tb_);
      chk("tx gap", 32'((s == 0) ? gap(16'hFFFE, 16) : T1_GAP * 16),
          32'(tb_ - ta));
      wait_ev(3, ta);
      wait_ev(3, tb_);
      chk("rx gap", 32'((s == 1) ? gap(16'hFFFE, 16) : T1_GAP * 16),
          32'(tb_ - ta));
      chk("request", 32'h0000_0000, 32'(irq));
      trig_lvl <= 1'b0;
      repeat (20) @(posedge clk);
      rdr(A_CT, rd, rs);
      chk("control", c | ((s == 1) ? C_EXT : 32'h0000_0000), rd);
      trig_lvl <= 1'b1;
      repeat (20) @(posedge clk);
    end
    $display("Test baud done");
    summarize();
  end
endmodule
